// >>> hdl/pcc_params.svh
// Summary of operation
// - power-off opcode starts the internal power-down sequence.
// - busy output held low during power-down, high again when done.
// - power-down disables pump, tcon, drivers, common, sensor; settings kept.
// - source and common outputs keep their previous state after power-down.
// - power-off, power-on and booster commands act only while busy is high.
// - power-on opcode, no parameters, runs power-up under the power settings.
// - busy output held low during power-up, high again when complete.
// - booster opcode takes seven bytes; on/off settings default 02h and 07h.
// - phase A soft-start in bits 1-0 selects 10, 20, 30 or 40 ms.
// - phase B soft-start in bits 3-2, same encoding as phase A.
// - mode-1 negative level code: -3 V minus 0.1 V steps to -11, else -15.
// - mode 0 uses fixed 15 V pos/neg rails, low pos still programmed; mode 1 uses programmed levels.
// - gate rail at 15 or 10 V clamps source levels 2 V inside it.
// - gate rail select codes 00..11 give 20, 17, 15, 10 V, default 00.
// - reset restores defaults, disables drivers, floats all outputs.
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH
`define PCC_CLK_MHZ        200
`define PCC_US_PER_MS      1000
`define PCC_SOFT_STEP_MS   10
`define PCC_POWER_DOWN_US  100
`define PCC_TIMER_W        20
`define PCC_OP_PWR_SET     8'h01
`define PCC_OP_POWER_OFF   8'h02
`define PCC_OP_POWER_ON    8'h04
`define PCC_OP_BOOSTER     8'h06
`define PCC_BOOST_N        7
`define PCC_PWR_N          6
`define PCC_BOOST_SFT_RST  8'h00
`define PCC_BOOST_ON_RST   8'h02
`define PCC_BOOST_OFF_RST  8'h07
`define PCC_PWR_EN_RST     8'h07
`define PCC_PWR_RST        8'h00
`define PCC_BI_SFT         0
`define PCC_PI_EN          0
`define PCC_PI_GATE        1
`define PCC_PI_LOWPOS0     2
`define PCC_PI_POS1        3
`define PCC_PI_NEG1        4
`define PCC_PI_LOWPOS1     5
`define PCC_SFT_A_LSB      0
`define PCC_SFT_B_LSB      2
`define PCC_EN_GATE_BIT    0
`define PCC_EN_SRC_BIT     1
`define PCC_EN_COM_BIT     2
`define PCC_LVL_BASE       8'h1e
`define PCC_LVL_MAX        8'h96
`define PCC_POS_CODE_MAX   7'h78
`define PCC_NEG_CODE_MAX   7'h50
`define PCC_GATE_20        8'hc8
`define PCC_GATE_17        8'haa
`define PCC_GATE_15        8'h96
`define PCC_GATE_10        8'h64
`define PCC_GATE_MARGIN    8'h14
`endif

// >>> hdl/pcc_pkg.sv
package pcc_pkg;
    typedef enum logic [1:0] {
        PCC_ST_IDLE = 2'h0,
        PCC_ST_UP_A = 2'h1,
        PCC_ST_UP_B = 2'h3,
        PCC_ST_DOWN = 2'h2
    } pcc_state_t;
    typedef enum logic [1:0] {
        PCC_CMD_NONE  = 2'h0,
        PCC_CMD_PWR   = 2'h1,
        PCC_CMD_BOOST = 2'h2
    } pcc_cmd_t;
endpackage

// >>> hdl/pcc_byte_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pcc_byte_if;
    logic       valid;
    logic [7:0] data;
    logic       is_param;
    modport rx  (output valid, output data, output is_param);
    modport cmd (input valid, input data, input is_param);
endinterface
`default_nettype wire

// >>> hdl/pcc_spi_rx.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_spi_rx
    import pcc_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic sclk_pin,
    input  wire logic sdin_pin,
    input  wire logic cs_n_pin,
    input  wire logic dc_pin,
    pcc_byte_if.rx    byte_o
);
    localparam int PIN_SCLK = 0;
    localparam int PIN_SDIN = 1;
    localparam int PIN_CSN  = 2;
    localparam int PIN_DC   = 3;
    localparam logic [2:0] LAST_BIT = 3'h7;

    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic       sclk_prev_q;
    logic [7:0] shift_q;
    logic [2:0] cnt_q;
    logic       rise;

    // pins are asynchronous to mclk
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_q      <= 4'h4;
            sync_q      <= 4'h4;
            sclk_prev_q <= 1'b0;
        end else begin
            meta_q      <= {dc_pin, cs_n_pin, sdin_pin, sclk_pin};
            sync_q      <= meta_q;
            sclk_prev_q <= sync_q[PIN_SCLK];
        end
    end

    assign rise = sync_q[PIN_SCLK] & ~sclk_prev_q & ~sync_q[PIN_CSN];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            shift_q         <= 8'h00;
            cnt_q           <= 3'h0;
            byte_o.valid    <= 1'b0;
            byte_o.data     <= 8'h00;
            byte_o.is_param <= 1'b0;
        end else begin
            byte_o.valid <= 1'b0;
            if (sync_q[PIN_CSN]) begin
                cnt_q <= 3'h0;
            end else if (rise) begin
                shift_q <= {shift_q[6:0], sync_q[PIN_SDIN]};
                cnt_q   <= cnt_q + 3'h1;
                if (cnt_q == LAST_BIT) begin
                    byte_o.valid    <= 1'b1;
                    byte_o.data     <= {shift_q[6:0], sync_q[PIN_SDIN]};
                    byte_o.is_param <= sync_q[PIN_DC];
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> hdl/pcc_power_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcc_params.svh"
module pcc_power_ctrl
    import pcc_pkg::*;
#(
    parameter int SOFT_STEP_US  = `PCC_SOFT_STEP_MS * `PCC_US_PER_MS,
    parameter int POWER_DOWN_US = `PCC_POWER_DOWN_US
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       sclk_pin,
    input  wire logic       sdin_pin,
    input  wire logic       cs_n_pin,
    input  wire logic       data_command_select,
    input  wire logic       programmable_source_rail_mode,
    output logic            busy_n,
    output logic            charge_pump_en,
    output logic            tcon_en,
    output logic            source_drv_en,
    output logic            gate_drv_en,
    output logic            common_electrode_en,
    output logic            temp_sensor_en,
    output logic            phase_a_soft_start_active,
    output logic            phase_b_soft_start_active,
    output logic [5:0]      phase_a_on_setting,
    output logic [5:0]      phase_a_off_setting,
    output logic [5:0]      phase_b_on_setting,
    output logic [5:0]      phase_b_off_setting,
    output logic [5:0]      phase_c_on_setting,
    output logic [5:0]      phase_c_off_setting,
    output logic            source_driver_output_float,
    output logic            common_electrode_output_float,
    output logic            gate_output_float,
    output logic [7:0]      pos_source_level,
    output logic [7:0]      neg_source_level,
    output logic [7:0]      low_pos_source_level,
    output logic [7:0]      gate_rail_level
);
    // levels are magnitudes in tenths of a volt
    localparam int TICK_CYC = `PCC_CLK_MHZ;
    localparam int TW       = `PCC_TIMER_W;
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
    localparam logic [2:0] BOOST_LAST = 3'(`PCC_BOOST_N - 1);
    localparam logic [2:0] PWR_LAST   = 3'(`PCC_PWR_N - 1);

    pcc_byte_if byte_bus ();

    pcc_spi_rx u_rx (
        .mclk     (mclk),
        .rst      (rst),
        .sclk_pin (sclk_pin),
        .sdin_pin (sdin_pin),
        .cs_n_pin (cs_n_pin),
        .dc_pin   (data_command_select),
        .byte_o   (byte_bus.rx)
    );

    pcc_state_t  state_q;
    pcc_cmd_t    cmd_q;
    logic [2:0]  idx_q;
    logic [7:0]  boost_q [`PCC_BOOST_N];
    logic [7:0]  pwr_q   [`PCC_PWR_N];
    logic [7:0]  tick_cnt_q;
    logic        tick_q;
    logic [TW-1:0] wait_q;
    logic [1:0]  mode_sync_q;
    logic        is_opcode;
    logic        start_on;
    logic        start_off;
    logic        wait_done;
    logic [1:0]  sft_a;
    logic [1:0]  sft_b;

    // mode select pin, two-stage synchroniser
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_sync_q <= 2'h0;
        end else begin
            mode_sync_q <= {mode_sync_q[0], programmable_source_rail_mode};
        end
    end

    assign is_opcode = byte_bus.valid & ~byte_bus.is_param;
    // power-on, power-off and booster opcodes dropped while busy; host must poll
    assign start_on  = is_opcode & (byte_bus.data == `PCC_OP_POWER_ON) & busy_n;
    assign start_off = is_opcode & (byte_bus.data == `PCC_OP_POWER_OFF) & busy_n;

    // command and parameter index tracking
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmd_q <= PCC_CMD_NONE;
            idx_q <= 3'h0;
        end else if (is_opcode) begin
            idx_q <= 3'h0;
            case (byte_bus.data)
                `PCC_OP_PWR_SET: cmd_q <= PCC_CMD_PWR;
                `PCC_OP_BOOSTER: cmd_q <= busy_n ? PCC_CMD_BOOST : PCC_CMD_NONE;
                default:         cmd_q <= PCC_CMD_NONE;
            endcase
        end else if (byte_bus.valid) begin
            idx_q <= idx_q + 3'h1;
            if ((cmd_q == PCC_CMD_BOOST && idx_q == BOOST_LAST) ||
                (cmd_q == PCC_CMD_PWR && idx_q == PWR_LAST)) begin
                cmd_q <= PCC_CMD_NONE;
            end
        end
    end

    // booster settings; power-off leaves them untouched
    generate
        for (genvar i = 0; i < `PCC_BOOST_N; i++) begin : g_boost
            localparam logic [7:0] RST_V = (i == `PCC_BI_SFT) ? `PCC_BOOST_SFT_RST :
                                           (i % 2 == 1) ? `PCC_BOOST_ON_RST : `PCC_BOOST_OFF_RST;
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    boost_q[i] <= RST_V;
                end else if (byte_bus.valid && byte_bus.is_param &&
                             cmd_q == PCC_CMD_BOOST && idx_q == 3'(i)) begin
                    boost_q[i] <= byte_bus.data;
                end
            end
        end
    endgenerate

    // power settings
    generate
        for (genvar i = 0; i < `PCC_PWR_N; i++) begin : g_pwr
            localparam logic [7:0] RST_V = (i == `PCC_PI_EN) ? `PCC_PWR_EN_RST : `PCC_PWR_RST;
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    pwr_q[i] <= RST_V;
                end else if (byte_bus.valid && byte_bus.is_param &&
                             cmd_q == PCC_CMD_PWR && idx_q == 3'(i)) begin
                    pwr_q[i] <= byte_bus.data;
                end
            end
        end
    endgenerate

    assign phase_a_on_setting  = boost_q[1][5:0];
    assign phase_a_off_setting = boost_q[2][5:0];
    assign phase_b_on_setting  = boost_q[3][5:0];
    assign phase_b_off_setting = boost_q[4][5:0];
    assign phase_c_on_setting  = boost_q[5][5:0];
    assign phase_c_off_setting = boost_q[6][5:0];

    // microsecond enable from the fast clock
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= 8'h00;
            tick_q     <= 1'b0;
        end else begin
            tick_q     <= (tick_cnt_q == TICK_LAST);
            tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 8'h00 : tick_cnt_q + 8'h01;
        end
    end

    assign sft_a     = boost_q[`PCC_BI_SFT][`PCC_SFT_A_LSB +: 2];
    assign sft_b     = boost_q[`PCC_BI_SFT][`PCC_SFT_B_LSB +: 2];
    assign wait_done = tick_q && (wait_q == '0);

    // sequencer: 10 ms steps per soft-start code, +/- one tick
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= PCC_ST_IDLE;
            wait_q  <= '0;
        end else begin
            case (state_q)
                PCC_ST_IDLE: begin
                    if (start_on) begin
                        state_q <= PCC_ST_UP_A;
                        wait_q  <= TW'((int'(sft_a) + 1) * SOFT_STEP_US);
                    end else if (start_off) begin
                        state_q <= PCC_ST_DOWN;
                        wait_q  <= TW'(POWER_DOWN_US);
                    end
                end
                PCC_ST_UP_A: begin
                    if (wait_done) begin
                        state_q <= PCC_ST_UP_B;
                        wait_q  <= TW'((int'(sft_b) + 1) * SOFT_STEP_US);
                    end else if (tick_q) begin
                        wait_q <= wait_q - TW'(1);
                    end
                end
                PCC_ST_UP_B, PCC_ST_DOWN: begin
                    if (wait_done) begin
                        state_q <= PCC_ST_IDLE;
                    end else if (tick_q) begin
                        wait_q <= wait_q - TW'(1);
                    end
                end
                default: state_q <= PCC_ST_IDLE;
            endcase
        end
    end

    // busy follows the sequencer, low in the cycle after the opcode
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_n <= 1'b1;
        end else begin
            busy_n <= ~(start_on | start_off) &
                      ((state_q == PCC_ST_IDLE) |
                       (wait_done & (state_q != PCC_ST_UP_A)));
        end
    end

    // supply enables
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            charge_pump_en            <= 1'b0;
            phase_a_soft_start_active <= 1'b0;
            phase_b_soft_start_active <= 1'b0;
            tcon_en                   <= 1'b0;
            source_drv_en             <= 1'b0;
            gate_drv_en               <= 1'b0;
            common_electrode_en       <= 1'b0;
            temp_sensor_en            <= 1'b0;
        end else if (start_off) begin
            charge_pump_en            <= 1'b0;
            phase_a_soft_start_active <= 1'b0;
            phase_b_soft_start_active <= 1'b0;
            tcon_en                   <= 1'b0;
            source_drv_en             <= 1'b0;
            gate_drv_en               <= 1'b0;
            common_electrode_en       <= 1'b0;
            temp_sensor_en            <= 1'b0;
        end else if (start_on) begin
            charge_pump_en            <= 1'b1;
            phase_a_soft_start_active <= 1'b1;
            temp_sensor_en            <= 1'b1;
        end else if (state_q == PCC_ST_UP_A && wait_done) begin
            phase_a_soft_start_active <= 1'b0;
            phase_b_soft_start_active <= 1'b1;
        end else if (state_q == PCC_ST_UP_B && wait_done) begin
            // rails enabled by the power settings
            phase_b_soft_start_active <= 1'b0;
            tcon_en                   <= 1'b1;
            gate_drv_en               <= pwr_q[`PCC_PI_EN][`PCC_EN_GATE_BIT];
            source_drv_en             <= pwr_q[`PCC_PI_EN][`PCC_EN_SRC_BIT];
            common_electrode_en       <= pwr_q[`PCC_PI_EN][`PCC_EN_COM_BIT];
        end
    end

    // outputs float from reset until a power-up drives them; power-down keeps them
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            source_driver_output_float    <= 1'b1;
            common_electrode_output_float <= 1'b1;
            gate_output_float             <= 1'b1;
        end else if (state_q == PCC_ST_UP_B && wait_done) begin
            source_driver_output_float    <= ~pwr_q[`PCC_PI_EN][`PCC_EN_SRC_BIT];
            common_electrode_output_float <= ~pwr_q[`PCC_PI_EN][`PCC_EN_COM_BIT];
            gate_output_float             <= ~pwr_q[`PCC_PI_EN][`PCC_EN_GATE_BIT];
        end
        // no power-down branch: prior 0 V or floating state holds
    end

    function automatic logic [7:0] pos_level(input logic [6:0] code);
        pos_level = (code <= `PCC_POS_CODE_MAX) ? `PCC_LVL_BASE + {1'b0, code} : `PCC_LVL_MAX;
    endfunction

    function automatic logic [7:0] neg_level(input logic [6:0] code);
        neg_level = (code <= `PCC_NEG_CODE_MAX) ? `PCC_LVL_BASE + {1'b0, code} : `PCC_LVL_MAX;
    endfunction

    function automatic logic [7:0] gate_level(input logic [1:0] sel);
        case (sel)
            2'h0:    gate_level = `PCC_GATE_20;
            2'h1:    gate_level = `PCC_GATE_17;
            2'h2:    gate_level = `PCC_GATE_15;
            default: gate_level = `PCC_GATE_10;
        endcase
    endfunction

    logic [7:0] gate_c;
    logic [7:0] limit_c;
    logic       clamp_c;
    logic [7:0] pos_c;
    logic [7:0] neg_c;
    logic [7:0] low_c;

    // only the two lower gate rails need clamping
    always_comb begin
        gate_c  = gate_level(pwr_q[`PCC_PI_GATE][1:0]);
        clamp_c = (gate_c == `PCC_GATE_15) || (gate_c == `PCC_GATE_10);
        limit_c = gate_c - `PCC_GATE_MARGIN;
        if (mode_sync_q[1]) begin
            pos_c = pos_level(pwr_q[`PCC_PI_POS1][6:0]);
            neg_c = neg_level(pwr_q[`PCC_PI_NEG1][6:0]);
            low_c = pos_level(pwr_q[`PCC_PI_LOWPOS1][6:0]);
        end else begin
            pos_c = `PCC_LVL_MAX;
            neg_c = `PCC_LVL_MAX;
            low_c = pos_level(pwr_q[`PCC_PI_LOWPOS0][6:0]);
        end
        if (clamp_c) begin
            pos_c = (pos_c > limit_c) ? limit_c : pos_c;
            neg_c = (neg_c > limit_c) ? limit_c : neg_c;
            low_c = (low_c > limit_c) ? limit_c : low_c;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pos_source_level     <= 8'h00;
            neg_source_level     <= 8'h00;
            low_pos_source_level <= 8'h00;
            gate_rail_level      <= 8'h00;
        end else begin
            pos_source_level     <= pos_c;
            neg_source_level     <= neg_c;
            low_pos_source_level <= low_c;
            gate_rail_level      <= gate_c;
        end
    end
endmodule
`default_nettype wire

// >>> verification/pcc_power_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_ctrl_props #(
    parameter int SOFT_STEP_US  = 10000,
    parameter int POWER_DOWN_US = 100
) (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       busy_n,
    input wire logic       charge_pump_en,
    input wire logic       tcon_en,
    input wire logic       source_drv_en,
    input wire logic       gate_drv_en,
    input wire logic       common_electrode_en,
    input wire logic       temp_sensor_en,
    input wire logic       phase_a_soft_start_active,
    input wire logic       phase_b_soft_start_active,
    input wire logic       source_driver_output_float,
    input wire logic [7:0] pos_source_level,
    input wire logic [7:0] neg_source_level,
    input wire logic [7:0] low_pos_source_level,
    input wire logic [7:0] gate_rail_level
);
    localparam int US = 200;
    logic [31:0] a_cnt_q;
    logic [31:0] d_cnt_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) a_cnt_q <= '0;
        else a_cnt_q <= phase_a_soft_start_active ? a_cnt_q + 32'h1 : '0;
    end
    // power-down only: busy low, pump off
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) d_cnt_q <= '0;
        else d_cnt_q <= (!busy_n && !charge_pump_en) ? d_cnt_q + 32'h1 : '0;
    end
    off_all_low_a: assert property (
        $fell(busy_n) && !charge_pump_en |-> !(tcon_en | source_drv_en | gate_drv_en | common_electrode_en
        | temp_sensor_en)) else $error("enable left on at power-down");
    busy_soft_a: assert property (
        phase_a_soft_start_active || phase_b_soft_start_active |-> !busy_n) else $error("busy high in soft start");
    float_hold_a: assert property (
        $changed(source_driver_output_float) |-> $rose(busy_n) && tcon_en) else $error("source float moved");
    phase_order_a: assert property (
        $fell(phase_a_soft_start_active) |-> phase_b_soft_start_active && !busy_n) else $error("phase b missing");
    up_done_a: assert property (
        $fell(phase_b_soft_start_active) |-> busy_n && tcon_en && charge_pump_en) else $error("power-up end wrong");
    soft_a_len_a: assert property (
        $fell(phase_a_soft_start_active) |-> a_cnt_q >= SOFT_STEP_US * US - US
        && a_cnt_q <= 4 * SOFT_STEP_US * US + US) else $error("phase a length");
    down_len_a: assert property (
        $rose(busy_n) && !charge_pump_en |-> d_cnt_q >= POWER_DOWN_US * US - US
        && d_cnt_q <= POWER_DOWN_US * US + US) else $error("power-down length");
    clamp_ten_a: assert property (
        (gate_rail_level == 8'h64) [*2] |-> pos_source_level <= 8'h50 && neg_source_level <= 8'h50
        && low_pos_source_level <= 8'h50) else $error("level not clamped");
    cover property ($fell(phase_b_soft_start_active));
    cover property ($rose(busy_n) && !charge_pump_en);
    cover property (gate_rail_level == 8'h64);
endmodule
bind pcc_power_ctrl pcc_ctrl_props #(.SOFT_STEP_US(SOFT_STEP_US), .POWER_DOWN_US(POWER_DOWN_US)) pcc_ctrl_props_i (.*);
`default_nettype wire

// >>> verification/pcc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_host_model (
    input  wire logic mclk,
    output logic      sclk_pin,
    output logic      sdin_pin,
    output logic      cs_n_pin,
    output logic      data_command_select
);
    initial begin
        sclk_pin = 1'h0;
        sdin_pin = 1'h0;
        cs_n_pin = 1'h1;
        data_command_select = 1'h0;
    end
    // four mclk per half period, receiver needs three
    task automatic send_byte(input logic dc, input logic [7:0] b);
        @(posedge mclk);
        cs_n_pin <= 1'h0;
        data_command_select <= dc;
        for (int i = 7; i >= 0; i--) begin
            sdin_pin <= b[i];
            repeat (4) @(posedge mclk);
            sclk_pin <= 1'h1;
            repeat (4) @(posedge mclk);
            sclk_pin <= 1'h0;
        end
        repeat (4) @(posedge mclk);
        cs_n_pin <= 1'h1;
        // flip released lines: stale bits never look valid
        sdin_pin <= ~b[0];
        data_command_select <= ~dc;
        repeat (4) @(posedge mclk);
    endtask
    task automatic cmd(input logic [7:0] op, input int n, input logic [7:0] p [7]);
        send_byte(1'h0, op);
        for (int i = 0; i < n; i++) begin
            send_byte(1'h1, p[i]);
        end
    endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcc_params.svh"
module testbench;
    localparam int SOFT = 5;
    localparam int DOWN = 5;
    localparam int US   = 200;
    logic       mclk;
    logic       rst;
    logic       programmable_source_rail_mode;
    wire logic  sclk_pin, sdin_pin, cs_n_pin, data_command_select;
    logic       busy_n, charge_pump_en, tcon_en, source_drv_en, gate_drv_en, common_electrode_en, temp_sensor_en;
    logic       phase_a_soft_start_active, phase_b_soft_start_active;
    logic [5:0] phase_a_on_setting, phase_a_off_setting, phase_b_on_setting, phase_b_off_setting;
    logic [5:0] phase_c_on_setting, phase_c_off_setting;
    logic       source_driver_output_float, common_electrode_output_float, gate_output_float;
    logic [7:0] pos_source_level, neg_source_level, low_pos_source_level, gate_rail_level;
    int         errors = 0;
    int         checks_done = 0;
    pcc_power_ctrl #(.SOFT_STEP_US(SOFT), .POWER_DOWN_US(DOWN)) pcc_power_ctrl_i (.*);
    pcc_host_model pcc_host_model_i (.*);
    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string w, input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", w, exp, seen);
        end
    endtask
    function automatic logic sig(input int k);
        return k == 0 ? busy_n : k == 1 ? phase_a_soft_start_active : phase_b_soft_start_active;
    endfunction
    task automatic wait_for(input int k, input logic v, input int lim, output int n);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (sig(k) !== v && n < lim);
        if (sig(k) !== v) begin
            errors++;
            $display("MISMATCH wait %0d expected %h seen %h", k, v, sig(k));
            print_verdict();
        end
    endtask
    function automatic logic [5:0] enables();
        return {charge_pump_en, tcon_en, source_drv_en, gate_drv_en, common_electrode_en, temp_sensor_en};
    endfunction
    function automatic logic [35:0] settings();
        return {phase_a_on_setting, phase_a_off_setting, phase_b_on_setting, phase_b_off_setting,
                phase_c_on_setting, phase_c_off_setting};
    endfunction
    task automatic t_reset();
        check("busy_n", busy_n, 1'h1);
        check("enables", enables(), 6'h0);
        check("floats", {source_driver_output_float, common_electrode_output_float, gate_output_float}, 3'h7);
        check("booster", settings(), {6'h02, 6'h07, 6'h02, 6'h07, 6'h02, 6'h07});
        check("levels", {gate_rail_level, pos_source_level, neg_source_level, low_pos_source_level},
              {8'hc8, 8'h96, 8'h96, 8'h1e});
        $display("test reset done");
    endtask
    task automatic t_power_on(input int sa, input int sb);
        int n;
        wait_for(0, 1'h1, 10, n);
        pcc_host_model_i.cmd(`PCC_OP_POWER_ON, 0, '{default: 8'h00});
        wait_for(0, 1'h0, 10, n);
        check("pump up", {charge_pump_en, temp_sensor_en, phase_a_soft_start_active}, 3'h7);
        wait_for(1, 1'h0, 5 * SOFT * US, n);
        check("phase a time", n inside {[(sa + 1) * SOFT * US - US : (sa + 1) * SOFT * US + US]}, 1'h1);
        check("phase b on", {phase_b_soft_start_active, busy_n}, 2'h2);
        wait_for(2, 1'h0, 5 * SOFT * US, n);
        check("phase b time", n inside {[(sb + 1) * SOFT * US - US : (sb + 1) * SOFT * US + US]}, 1'h1);
        check("powered", {busy_n, enables()}, 7'h7f);
        check("driven", {source_driver_output_float, common_electrode_output_float, gate_output_float}, 3'h0);
        $display("test power-on done");
    endtask
    task automatic t_power_off();
        int n;
        wait_for(0, 1'h1, 10, n);
        pcc_host_model_i.cmd(`PCC_OP_POWER_OFF, 0, '{default: 8'h00});
        wait_for(0, 1'h0, 10, n);
        check("all off", enables(), 6'h0);
        check("outputs kept", {source_driver_output_float, common_electrode_output_float}, 2'h0);
        pcc_host_model_i.cmd(`PCC_OP_POWER_ON, 0, '{default: 8'h00});
        pcc_host_model_i.cmd(`PCC_OP_BOOSTER, 7, '{default: 8'h3f});
        check("still busy", busy_n, 1'h0);
        wait_for(0, 1'h1, DOWN * US, n);
        repeat (4) @(negedge mclk);
        check("pump refused", enables(), 6'h0);
        check("booster kept", settings(), {6'h02, 6'h07, 6'h02, 6'h07, 6'h02, 6'h07});
        $display("test power-off done");
    endtask
    task automatic t_booster();
        pcc_host_model_i.cmd(`PCC_OP_BOOSTER, 7, '{8'h07, 8'h3f, 8'h01, 8'h2a, 8'h15, 8'h00, 8'hfe});
        repeat (4) @(negedge mclk);
        check("booster", settings(), {6'h3f, 6'h01, 6'h2a, 6'h15, 6'h00, 6'h3e});
        $display("test booster done");
    endtask
    task automatic power_setting_cmd(input logic [1:0] gc, input logic [7:0] neg1);
        // pos levels >= low pos levels
        pcc_host_model_i.cmd(`PCC_OP_PWR_SET, 6, '{8'h07, {6'h00, gc}, 8'h78, 8'h14, neg1, 8'h00, 8'h00});
        repeat (8) @(negedge mclk);
    endtask
    task automatic t_levels();
        logic [7:0] g [4] = '{8'hc8, 8'haa, 8'h96, 8'h64};
        logic [7:0] c [4] = '{8'h00, 8'h50, 8'h51, 8'h7f};
        logic [7:0] e [4] = '{8'h1e, 8'h6e, 8'h96, 8'h96};
        logic [7:0] lim;
        for (int k = 0; k < 4; k++) begin
            power_setting_cmd(2'(k), 8'h14);
            lim = g[k] > 8'h96 ? 8'h96 : g[k] - 8'h14;
            check("gate", gate_rail_level, g[k]);
            check("fixed_source_rail_mode", {pos_source_level, neg_source_level, low_pos_source_level}, {lim, lim, lim});
        end
        @(posedge mclk);
        programmable_source_rail_mode <= 1'h1;
        for (int k = 0; k < 4; k++) begin
            power_setting_cmd(2'h0, c[k]);
            check("neg programmable_source_rail_mode", neg_source_level, e[k]);
        end
        check("pos programmable_source_rail_mode", {pos_source_level, low_pos_source_level}, {8'h32, 8'h1e});
        power_setting_cmd(2'h3, 8'h50);
        check("neg clamp", neg_source_level, 8'h50);
        $display("test levels done");
    endtask
    initial begin
        rst = 1'h1;
        programmable_source_rail_mode = 1'h0;
        repeat (5) @(posedge mclk);
        rst <= 1'h0;
        repeat (4) @(negedge mclk);
        t_reset();
        t_power_on(0, 0);
        t_power_off();
        t_booster();
        t_power_on(3, 1);
        t_levels();
        print_verdict();
    end
endmodule
`default_nettype wire
